// ### logic/atfs_pkg.sv
// Function
// - Primary status read in level-interrupt I/O config 1-3 drops request
// - Busy flag is one while an internal operation runs
// - Read, write, seek accepted only with ready and seek complete
// - Status bit 5 shows the write fault condition
// - Data request set while transfer may proceed, cleared by next command
// - Status bit 2 shows corrected data error
// - Index flag always reads zero
// - Error bit set on failed command, cleared by next command
// - Alternate status mirrors status and never drops interrupt request
// - Decoder accepts write codes 30h, 31h, C5h and CDh
// - Code 38h starts a sector write without erase
// - Only valid parameters used; feature register only for code EFh
// - Code 90h runs diagnostics using only the drive select bit
// - Code 91h sets drive parameters from count, drive and head
// - Soft reset bit holds task file in reset until cleared; the core leaves the feature register unchanged
// - Soft reset leaves card configuration registers untouched
// - Interrupt disable bit one gates the interrupt request off
// - Drive address bits 5 to 2 are inverted head select bits
// - Head number in drive/head bits 3 to 0 selects the head
package atfs_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFS_DATA      = 4'h0;
  localparam logic [3:0] OFS_ERROR     = 4'h1;
  localparam logic [3:0] OFS_FEATURE   = 4'h1;
  localparam logic [3:0] OFS_SEC_CNT   = 4'h2;
  localparam logic [3:0] OFS_SEC_NUM   = 4'h3;
  localparam logic [3:0] OFS_CYL_LO    = 4'h4;
  localparam logic [3:0] OFS_CYL_HI    = 4'h5;
  localparam logic [3:0] OFS_DRV_HEAD  = 4'h6;
  localparam logic [3:0] OFS_STATUS    = 4'h7;
  localparam logic [3:0] OFS_COMMAND   = 4'h7;
  localparam logic [3:0] OFS_ALT_STAT  = 4'he;
  localparam logic [3:0] OFS_DEV_CTRL  = 4'he;
  localparam logic [3:0] OFS_DRV_ADDR  = 4'hf;
  // Card-side configuration word, kept across soft reset
  localparam logic [3:0] OFS_CONFIG    = 4'h8;
  // Card-side event inputs offset (write fault, corrected); not decoded by the core, reads zero
  localparam logic [3:0] OFS_EVENTS    = 4'h9;
  // Status field positions
  localparam int BIT_BUSY   = 7;
  localparam int BIT_READY  = 6;
  localparam int BIT_FAULT  = 5;
  localparam int BIT_SEEK   = 4;
  localparam int BIT_DREQ   = 3;
  localparam int BIT_ECC    = 2;
  localparam int BIT_INDEX  = 1;
  localparam int BIT_ERR    = 0;
  // Error register field positions
  localparam int BIT_ABORT  = 2;
  // Device control field positions
  localparam int BIT_RESET  = 2;
  localparam int BIT_IRQ_OFF = 1;
  // Reset values
  localparam logic [7:0] RST_SEC_CNT  = 8'h01;
  localparam logic [7:0] RST_DRV_HEAD = 8'ha0;
  localparam logic [7:0] RST_CONFIG   = 8'h00;
  // Busy countdown load for an accepted command; the card stays busy one cycle longer
  localparam int BUSY_NS    = 100;
  localparam int CLK_NS     = 5;
  localparam logic [7:0] BUSY_CYCLES = 8'((BUSY_NS + CLK_NS - 1) / CLK_NS);
  // Index of the last data word in a sector
  localparam logic [7:0] SECTOR_WORDS = 8'hff;
  // Command codes
  localparam logic [7:0] CMD_RD_SEC0  = 8'h20;
  localparam logic [7:0] CMD_RD_SEC1  = 8'h21;
  localparam logic [7:0] CMD_RD_LNG0  = 8'h22;
  localparam logic [7:0] CMD_RD_LNG1  = 8'h23;
  localparam logic [7:0] CMD_WR_SEC0  = 8'h30;
  localparam logic [7:0] CMD_WR_SEC1  = 8'h31;
  localparam logic [7:0] CMD_WR_NOER  = 8'h38;
  localparam logic [7:0] CMD_VFY0     = 8'h40;
  localparam logic [7:0] CMD_VFY1     = 8'h41;
  localparam logic [7:0] CMD_DIAG     = 8'h90;
  localparam logic [7:0] CMD_INIT_PAR = 8'h91;
  localparam logic [7:0] CMD_RD_MUL   = 8'hc4;
  localparam logic [7:0] CMD_WR_MUL   = 8'hc5;
  localparam logic [7:0] CMD_WR_MUL_NE = 8'hcd;
  localparam logic [7:0] CMD_SET_FEAT = 8'hef;
  localparam logic [3:0] CMD_SEEK_HI  = 4'h7;
  // Sequencer states
  typedef enum logic [4:0] {
    ATFS_ST_IDLE = 5'b00001,
    ATFS_ST_BUSY = 5'b00010,
    ATFS_ST_RD   = 5'b00100,
    ATFS_ST_WR   = 5'b01000,
    ATFS_ST_RST  = 5'b10000
  } atfs_state_e;
  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } atfs_req_s;
endpackage : atfs_pkg

// ### logic/atfs_core.sv
`timescale 1ns/1ps
module atfs_core (
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic       WRITE_FAULT_I,
  input  wire logic       CORRECTED_I,
  output logic      [7:0] RDATA_O,
  output logic            IREQ_N_O,
  output logic            SOFT_RESET_O
);
  atfs_pkg::atfs_req_s   req;
  atfs_pkg::atfs_state_e state;
  atfs_pkg::atfs_state_e next_state;
  logic [1:0] fault_sync;
  logic [1:0] corrected_sync;
  logic [7:0] sec_cnt;
  logic [7:0] sec_num;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] drv_head;
  logic [7:0] feature;
  logic [7:0] config_word;
  logic [7:0] err_reg;
  logic       err_flag;
  logic       drive_ready_flag;
  logic       seek_complete_flag;
  logic       corrected_data_flag;
  logic       soft_reset_bit;
  logic       interrupt_disable_bit;
  logic       irq_pend;
  logic [7:0] busy_cnt;
  logic [7:0] word_cnt;
  logic [7:0] sec_left;
  logic [7:0] cmd_latch;
  logic [7:0] status;
  logic [7:0] drive_address;
  logic       cmd_wr;
  logic       cmd_known;
  logic       cmd_media;
  logic       cmd_write;
  logic       cmd_reject;
  logic       busy_flag;
  logic       data_request_flag;
  logic       write_fault_flag;
  logic       index_flag;
  logic       level_io_mode;
  logic       stat_rd;
  logic       data_acc;

  // Bundle the register port
  assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
  assign cmd_wr   = req.wr && req.addr == atfs_pkg::OFS_COMMAND;
  assign stat_rd  = req.rd && req.addr == atfs_pkg::OFS_STATUS;
  assign data_acc = (req.rd || req.wr) && req.addr == atfs_pkg::OFS_DATA;
  // Config index in bits 2:0, level interrupt mode in bit 3
  assign level_io_mode = config_word[3] && config_word[2:0] != 3'h0
                         && config_word[2:0] <= 3'h3;

  // Asynchronous card events pass two flops
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fault_sync     <= 2'h0;
      corrected_sync <= 2'h0;
    end else begin
      fault_sync     <= {fault_sync[0], WRITE_FAULT_I};
      corrected_sync <= {corrected_sync[0], CORRECTED_I};
    end
  end

  // Command decode
  always_comb begin
    cmd_known = 1'b1;
    cmd_media = 1'b0;
    cmd_write = 1'b0;
    unique case (cmd_latch)
      atfs_pkg::CMD_RD_SEC0, atfs_pkg::CMD_RD_SEC1, atfs_pkg::CMD_RD_MUL,
      atfs_pkg::CMD_VFY0, atfs_pkg::CMD_VFY1,
      atfs_pkg::CMD_RD_LNG0, atfs_pkg::CMD_RD_LNG1: cmd_media = 1'b1;
      atfs_pkg::CMD_WR_SEC0, atfs_pkg::CMD_WR_SEC1, atfs_pkg::CMD_WR_NOER,
      atfs_pkg::CMD_WR_MUL, atfs_pkg::CMD_WR_MUL_NE: begin
        // Multiple writes lack bit 4, so the class is decoded here
        cmd_media = 1'b1;
        cmd_write = 1'b1;
      end
      atfs_pkg::CMD_DIAG, atfs_pkg::CMD_INIT_PAR,
      atfs_pkg::CMD_SET_FEAT: cmd_media = 1'b0;
      default: begin
        cmd_known = cmd_latch[7:4] == atfs_pkg::CMD_SEEK_HI;
        cmd_media = cmd_known;
      end
    endcase
  end
  // media requests need ready and seek complete
  assign cmd_reject = !cmd_known
                      || (cmd_media && !(drive_ready_flag
                                         && seek_complete_flag));

  // Command sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      atfs_pkg::ATFS_ST_IDLE, atfs_pkg::ATFS_ST_RD,
      atfs_pkg::ATFS_ST_WR: begin
        if (cmd_wr)
          next_state = atfs_pkg::ATFS_ST_BUSY;
        else if (state != atfs_pkg::ATFS_ST_IDLE && data_acc
                 && word_cnt == atfs_pkg::SECTOR_WORDS
                 && sec_left == 8'h01)
          next_state = atfs_pkg::ATFS_ST_IDLE;
      end
      atfs_pkg::ATFS_ST_BUSY: begin
        if (busy_cnt == 8'h00) begin
          if (cmd_reject || !cmd_media || cmd_latch[7:4]
              == atfs_pkg::CMD_SEEK_HI)
            next_state = atfs_pkg::ATFS_ST_IDLE;
          else if (cmd_write)
            next_state = atfs_pkg::ATFS_ST_WR;
          else if (cmd_latch == atfs_pkg::CMD_VFY0
                   || cmd_latch == atfs_pkg::CMD_VFY1)
            next_state = atfs_pkg::ATFS_ST_IDLE;
          else
            next_state = atfs_pkg::ATFS_ST_RD;
        end
      end
      atfs_pkg::ATFS_ST_RST: next_state = atfs_pkg::ATFS_ST_RST;
    endcase
    // reset held while bit stays set
    if (soft_reset_bit)
      next_state = atfs_pkg::ATFS_ST_RST;
    else if (state == atfs_pkg::ATFS_ST_RST)
      next_state = atfs_pkg::ATFS_ST_IDLE;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I)
      state <= atfs_pkg::ATFS_ST_IDLE;
    else
      state <= next_state;
  end

  // Busy countdown and sector bookkeeping
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      busy_cnt  <= 8'h00;
      word_cnt  <= 8'h00;
      sec_left  <= 8'h00;
      cmd_latch <= 8'h00;
    end else if (soft_reset_bit) begin
      busy_cnt <= 8'h00;
      word_cnt <= 8'h00;
    end else if (cmd_wr && state != atfs_pkg::ATFS_ST_BUSY) begin
      cmd_latch <= req.wdata;
      busy_cnt  <= atfs_pkg::BUSY_CYCLES;
      word_cnt  <= 8'h00;
      // count register latched for every accepted command
      sec_left  <= sec_cnt;
    end else if (state == atfs_pkg::ATFS_ST_BUSY) begin
      busy_cnt <= busy_cnt - 8'h01;
    end else if (data_acc) begin
      word_cnt <= word_cnt + 8'h01;
      if (word_cnt == atfs_pkg::SECTOR_WORDS)
        sec_left <= sec_left - 8'h01;
    end
  end

  // Task file parameters; soft reset restores all but feature
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sec_cnt  <= atfs_pkg::RST_SEC_CNT;
      sec_num  <= 8'h01;
      cyl_lo   <= 8'h00;
      cyl_hi   <= 8'h00;
      drv_head <= atfs_pkg::RST_DRV_HEAD;
      feature  <= 8'h00;
    end else if (soft_reset_bit) begin
      sec_cnt  <= atfs_pkg::RST_SEC_CNT;
      sec_num  <= 8'h01;
      cyl_lo   <= 8'h00;
      cyl_hi   <= 8'h00;
      drv_head <= atfs_pkg::RST_DRV_HEAD;
    end else if (req.wr && state != atfs_pkg::ATFS_ST_BUSY) begin
      unique case (req.addr)
        atfs_pkg::OFS_FEATURE:  feature  <= req.wdata;
        atfs_pkg::OFS_SEC_CNT:  sec_cnt  <= req.wdata;
        atfs_pkg::OFS_SEC_NUM:  sec_num  <= req.wdata;
        atfs_pkg::OFS_CYL_LO:   cyl_lo   <= req.wdata;
        atfs_pkg::OFS_CYL_HI:   cyl_hi   <= req.wdata;
        atfs_pkg::OFS_DRV_HEAD: drv_head <= req.wdata;
        default: ;
      endcase
    end
  end

  // Configuration survives soft reset, only hardware reset clears it
  // configuration kept
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I)
      config_word <= atfs_pkg::RST_CONFIG;
    else if (req.wr && req.addr == atfs_pkg::OFS_CONFIG)
      config_word <= req.wdata;
  end

  // Device control: bits 7..4 ignored
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      soft_reset_bit        <= 1'b0;
      interrupt_disable_bit <= 1'b0;
    end else if (req.wr && req.addr == atfs_pkg::OFS_DEV_CTRL) begin
      soft_reset_bit        <= req.wdata[atfs_pkg::BIT_RESET];
      interrupt_disable_bit <= req.wdata[atfs_pkg::BIT_IRQ_OFF];
    end
  end

  // Ready and seek complete drop during soft reset
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      drive_ready_flag   <= 1'b0;
      seek_complete_flag <= 1'b0;
    end else begin
      drive_ready_flag   <= !soft_reset_bit;
      seek_complete_flag <= !soft_reset_bit;
    end
  end

  // Error and corrected flags; next command clears, event wins
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      err_flag            <= 1'b0;
      err_reg             <= 8'h00;
      corrected_data_flag <= 1'b0;
    end else if (soft_reset_bit) begin
      err_flag            <= 1'b0;
      err_reg             <= 8'h00;
      corrected_data_flag <= 1'b0;
    end else if (state == atfs_pkg::ATFS_ST_BUSY && busy_cnt == 8'h00
                 && cmd_reject) begin
      err_flag <= 1'b1;
      err_reg  <= 8'h01 << atfs_pkg::BIT_ABORT;
      // A correction event in the abort cycle is not lost
      if (corrected_sync[1])
        corrected_data_flag <= 1'b1;
    end else if (cmd_wr) begin
      err_flag            <= 1'b0;
      err_reg             <= 8'h00;
      corrected_data_flag <= corrected_sync[1];
    end else if (corrected_sync[1]) begin
      corrected_data_flag <= 1'b1;
    end
  end

  // Interrupt pending on command completion
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I)
      irq_pend <= 1'b0;
    else if (state == atfs_pkg::ATFS_ST_BUSY
             && next_state != atfs_pkg::ATFS_ST_BUSY)
      irq_pend <= 1'b1;
    else if (stat_rd && level_io_mode)
      irq_pend <= 1'b0;
  end

  assign busy_flag = state == atfs_pkg::ATFS_ST_BUSY
                     || state == atfs_pkg::ATFS_ST_RST;
  // data request while transfer may proceed
  assign data_request_flag = state == atfs_pkg::ATFS_ST_RD
                             || state == atfs_pkg::ATFS_ST_WR;
  assign write_fault_flag = fault_sync[1];
  assign index_flag = 1'b0;
  assign status = {busy_flag, drive_ready_flag, write_fault_flag,
                   seek_complete_flag, data_request_flag,
                   corrected_data_flag, index_flag, err_flag};
  // inverted head select, unknown bits read one
  assign drive_address = {2'h3, ~drv_head[3:0], 2'h3};

  // Read data one cycle after the strobe
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I)
      RDATA_O <= 8'h00;
    else if (req.rd) begin
      unique case (req.addr)
        atfs_pkg::OFS_ERROR:    RDATA_O <= err_reg;
        atfs_pkg::OFS_SEC_CNT:  RDATA_O <= sec_cnt;
        atfs_pkg::OFS_SEC_NUM:  RDATA_O <= sec_num;
        atfs_pkg::OFS_CYL_LO:   RDATA_O <= cyl_lo;
        atfs_pkg::OFS_CYL_HI:   RDATA_O <= cyl_hi;
        atfs_pkg::OFS_DRV_HEAD: RDATA_O <= drv_head;
        atfs_pkg::OFS_STATUS,
        atfs_pkg::OFS_ALT_STAT: RDATA_O <= status;
        atfs_pkg::OFS_DRV_ADDR: RDATA_O <= drive_address;
        atfs_pkg::OFS_CONFIG:   RDATA_O <= config_word;
        default:                RDATA_O <= 8'h00;
      endcase
    end else
      RDATA_O <= 8'h00;
  end

  // Interrupt and soft reset outputs from flops
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      IREQ_N_O     <= 1'b1;
      SOFT_RESET_O <= 1'b0;
    end else begin
      IREQ_N_O     <= !(irq_pend && !interrupt_disable_bit
                        && !(stat_rd && level_io_mode));
      SOFT_RESET_O <= soft_reset_bit;
    end
  end
endmodule // atfs_core

// ### tb/atfs_core_props.sv
`timescale 1ns/1ps
module atfs_core_props (
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic       WRITE_FAULT_I,
  input wire logic       CORRECTED_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       IREQ_N_O,
  input wire logic       SOFT_RESET_O
);
  localparam logic [3:0] A_ST = atfs_pkg::OFS_STATUS;
  localparam logic [3:0] A_CT = atfs_pkg::OFS_DEV_CTRL;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Soft reset bit of the write data
  wire ctrl_rst_bit = WDATA_I[atfs_pkg::BIT_RESET];
  // Command write, then a status poll
  sequence s_cmd; WR_I && ADDR_I == atfs_pkg::OFS_COMMAND; endsequence
  sequence s_poll; RD_I && ADDR_I == A_ST; endsequence
  property p_busy; s_cmd ##[1:3] s_poll |=> RDATA_O[7]; endproperty
  property p_rd_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
  property p_index;
    $past(RD_I) && $past(ADDR_I) == A_ST |-> !RDATA_O[1];
  endproperty
  property p_alt_irq;
    RD_I && ADDR_I == atfs_pkg::OFS_ALT_STAT && !IREQ_N_O |=> !IREQ_N_O;
  endproperty
  // Control bit flop, then the output flop: two edges
  property p_soft_rst_set;
    WR_I && ADDR_I == A_CT |=> ##1 SOFT_RESET_O == $past(ctrl_rst_bit, 2);
  endproperty
  property p_soft_rst_hold;
    SOFT_RESET_O && !(WR_I && ADDR_I == A_CT)
      && !$past(WR_I && ADDR_I == A_CT) |=> SOFT_RESET_O;
  endproperty
  property p_drv_addr;
    $past(RD_I) && $past(ADDR_I) == atfs_pkg::OFS_DRV_ADDR
      |-> RDATA_O[7:6] == 2'b11 && RDATA_O[1:0] == 2'b11;
  endproperty
  // Fault must have crossed the two sync flops
  property p_fault;
    WRITE_FAULT_I [*4] ##0 s_poll |=> RDATA_O[5] || RDATA_O[7];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
  a_index: assert property (p_index) else $error("index set");
  a_alt_irq: assert property (p_alt_irq) else $error("alt drop");
  a_soft_rst_set: assert property (p_soft_rst_set)
    else $error("soft reset not mirrored");
  a_soft_rst_hold: assert property (p_soft_rst_hold)
    else $error("soft reset dropped");
  a_drv_addr: assert property (p_drv_addr) else $error("drv addr");
  a_fault: assert property (p_fault) else $error("fault bit");
endmodule // atfs_core_props
bind atfs_core atfs_core_props i_props (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .WRITE_FAULT_I(WRITE_FAULT_I),
  .CORRECTED_I(CORRECTED_I), .RDATA_O(RDATA_O), .IREQ_N_O(IREQ_N_O),
  .SOFT_RESET_O(SOFT_RESET_O));

// ### tb/atfs_host_model.sv
`timescale 1ns/1ps
module atfs_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // Idle bus at time zero
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One-cycle write; released lines flip so stale values never match
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == atfs_pkg::OFS_DEV_CTRL) ? ((d | 8'h08) & 8'hfe) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
endmodule // atfs_host_model

// ### tb/atfs_core_tb_top.sv
`timescale 1ns/1ps
module atfs_core_tb_top;
  logic       clk, rst, wf, corrected, wr, rd, ireq_n, soft_rst;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         failures, comparisons, cycles;
  // Clock and run ceiling
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  atfs_core i_dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .WRITE_FAULT_I(wf),
    .CORRECTED_I(corrected), .RDATA_O(rdata), .IREQ_N_O(ireq_n),
    .SOFT_RESET_O(soft_rst));
  atfs_host_model i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic test_done();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(n, e, d);
  endtask
  // Poll alternate status so a pending request is left alone
  task automatic wait_rdy();
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      i_host.rd(atfs_pkg::OFS_ALT_STAT, d);
      if (d[7] === 1'b0) break;
    end
    chk("busy after wait", 8'h00, {7'h0, d[7]});
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [7:0] d;
    i_host.wr(atfs_pkg::OFS_COMMAND, c);
    // Other status bits are invalid while busy
    i_host.rd(atfs_pkg::OFS_STATUS, d);
    chk("busy status", 8'h01, {7'h0, d[7]});
    wait_rdy();
  endtask
  task automatic t_reset();
    st(atfs_pkg::OFS_STATUS, 8'h50, "reset status");
    st(atfs_pkg::OFS_ALT_STAT, 8'h50, "reset alt status");
    st(atfs_pkg::OFS_DRV_ADDR, 8'hff, "reset drive addr");
    st(4'h9, 8'h00, "unmapped");
    chk("reset irq", 8'h01, {7'h0, ireq_n});
    i_host.wr(atfs_pkg::OFS_DRV_HEAD, 8'ha5);
    st(atfs_pkg::OFS_DRV_ADDR, 8'heb, "drive addr head 5");
    $display("test reset and head done");
  endtask
  task automatic t_codes();
    logic [7:0] c [16] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'hc4, 8'h30, 8'h31,
      8'h38, 8'hc5, 8'hcd, 8'h40, 8'h41, 8'h90, 8'h91, 8'h70, 8'hef};
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      cmd(c[i]);
      e = (i < 10) ? 8'h58 : 8'h50;
      st(atfs_pkg::OFS_STATUS, e, "code");
    end
    cmd(8'hff);
    st(atfs_pkg::OFS_STATUS, 8'h51, "abort status");
    st(atfs_pkg::OFS_ERROR, 8'h04, "abort error");
    cmd(8'h90);
    st(atfs_pkg::OFS_STATUS, 8'h50, "error cleared");
    i_host.wr(atfs_pkg::OFS_COMMAND, 8'h20);
    i_host.wr(atfs_pkg::OFS_DRV_HEAD, 8'ha3);
    wait_rdy();
    st(atfs_pkg::OFS_DRV_ADDR, 8'heb, "head kept while busy");
    $display("test codes done");
  endtask
  task automatic t_irq();
    i_host.wr(atfs_pkg::OFS_CONFIG, 8'h09);
    st(atfs_pkg::OFS_STATUS, 8'h58, "status clears irq");
    chk("irq after read", 8'h01, {7'h0, ireq_n});
    cmd(8'h90);
    chk("irq raised", 8'h00, {7'h0, ireq_n});
    st(atfs_pkg::OFS_ALT_STAT, 8'h50, "alt status");
    chk("irq kept by alt", 8'h00, {7'h0, ireq_n});
    st(atfs_pkg::OFS_STATUS, 8'h50, "status");
    chk("irq dropped", 8'h01, {7'h0, ireq_n});
    i_host.wr(atfs_pkg::OFS_DEV_CTRL, 8'h02);
    cmd(8'h90);
    chk("irq disabled", 8'h01, {7'h0, ireq_n});
    i_host.wr(atfs_pkg::OFS_DEV_CTRL, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_soft_rst();
    i_host.wr(atfs_pkg::OFS_DEV_CTRL, 8'h04);
    @(posedge clk);
    #1 chk("soft reset on", 8'h01, {7'h0, soft_rst});
    repeat (8) @(posedge clk);
    #1 chk("soft reset held", 8'h01, {7'h0, soft_rst});
    i_host.wr(atfs_pkg::OFS_DEV_CTRL, 8'h00);
    @(posedge clk);
    #1 chk("soft reset off", 8'h00, {7'h0, soft_rst});
    wait_rdy();
    st(atfs_pkg::OFS_STATUS, 8'h50, "status after soft reset");
    st(atfs_pkg::OFS_DRV_ADDR, 8'hff, "head after soft reset");
    cmd(8'h90);
    chk("irq after soft reset", 8'h00, {7'h0, ireq_n});
    st(atfs_pkg::OFS_STATUS, 8'h50, "status");
    chk("config kept", 8'h01, {7'h0, ireq_n});
    $display("test soft reset done");
  endtask
  // Event inputs change only at a rising edge
  task automatic t_events();
    @(posedge clk);
    wf <= 1'b1;
    repeat (4) @(posedge clk);
    st(atfs_pkg::OFS_STATUS, 8'h70, "write fault");
    @(posedge clk);
    wf <= 1'b0;
    repeat (4) @(posedge clk);
    st(atfs_pkg::OFS_STATUS, 8'h50, "fault gone");
    @(posedge clk);
    corrected <= 1'b1;
    repeat (4) @(posedge clk);
    corrected <= 1'b0;
    repeat (4) @(posedge clk);
    st(atfs_pkg::OFS_STATUS, 8'h54, "corrected sticky");
    cmd(8'h90);
    st(atfs_pkg::OFS_STATUS, 8'h50, "corrected cleared");
    $display("test events done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    wf = 1'b0;
    corrected = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_codes();
    t_irq();
    t_soft_rst();
    t_events();
    test_done();
  end
endmodule // atfs_core_tb_top
